// >>> verilog/pdwc_top.sv
`timescale 1ns/1ns
`include "pdwc_regs.svh"

// Functional notes
// - With the wake-mux bit set, card and user-pin sources, and the keypad source when its interrupt enable is set, all raise external interrupt zero.
// - The merged wake interrupt reaches external interrupt zero 512 clock cycles after the wake count starts.
// - Reading the wake-routing register clears the wake-mux bit.
// - Oscillator and PLL are switched off exactly 32 cycles after a power-down request written outside a wake count.
// - During power-down the CPU is held halted and the request overrides all other power controls.
// - Bit 1 of the miscellaneous register puts the serial port in loopback.
// - Bit 0 of the miscellaneous register selects the serial port pin set.
// - Both control registers reset to zero.
// - Power-down turns the converter off only without bus supply and with on/off logic off, else standby.
// - A wake restores power and clocks, and the 512 count starts only once the clock runs.
module pdwc_top #(
   parameter int ADDR_W = 18
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              keypad_evt,
   input  wire logic              card_irq,
   input  wire logic [7:0]        user_pins,
   input  wire logic              bus_supply_ok,
   input  wire logic              onoff_is_on,
   input  wire logic              clk_stable,
   output logic                   ext_irq_zero,
   output logic                   card_irq_out,
   output logic                   keypad_irq_req,
   output logic                   osc_pll_off,
   output logic                   converter_off,
   output logic                   core_standby,
   output logic                   cpu_halt,
   output logic                   serial_loopback,
   output logic                   serial_pin_sel,
   output logic                   irq
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [12:0] pins_s;

   pdwc_sync #(.W(13)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({keypad_evt, card_irq, user_pins, bus_supply_ok,
                 onoff_is_on, clk_stable}),
      .q       (pins_s)
   );

   wire       kp_s     = pins_s[12];
   wire       card_s   = pins_s[11];
   wire [7:0] usr_s    = pins_s[10:3];
   wire       bus_s    = pins_s[2];
   wire       on_s     = pins_s[1];
   wire       clkok_s  = pins_s[0];

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic pdwc_pkg::pdwc_sel_t dec(input logic [ADDR_W-1:0] a);
      if (a == {`PDWC_WAKE_ROUTE_IDX, 2'b00})
         dec = pdwc_pkg::SEL_WAKE;
      else if (a == {`PDWC_MISC_CTRL_IDX, 2'b00})
         dec = pdwc_pkg::SEL_MISC;
      else if (a == {`PDWC_IRQ_STAT_IDX, 2'b00})
         dec = pdwc_pkg::SEL_IST;
      else if (a == {`PDWC_IRQ_MASK_IDX, 2'b00})
         dec = pdwc_pkg::SEL_IMSK;
      else if (a == {`PDWC_BLK_STAT_IDX, 2'b00})
         dec = pdwc_pkg::SEL_STAT;
      else
         dec = pdwc_pkg::SEL_NONE;
   endfunction : dec

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic              aw_got_r;
   logic              w_got_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [7:0]        wdata_r;
   logic              wstrb0_r;

   wire aw_fire   = s_axi_awvalid & s_axi_awready;
   wire w_fire    = s_axi_wvalid & s_axi_wready;
   wire have_aw   = aw_got_r | aw_fire;
   wire have_w    = w_got_r | w_fire;
   wire wr_fire   = have_aw & have_w;
   wire aw_got_nxt = have_aw & ~wr_fire;
   wire w_got_nxt  = have_w & ~wr_fire;
   wire bvalid_nxt = wr_fire | (s_axi_bvalid & ~s_axi_bready);

   wire [ADDR_W-1:0] wa  = aw_got_r ? awaddr_r : s_axi_awaddr;
   wire [7:0]        wd  = w_got_r ? wdata_r : s_axi_wdata[7:0];
   wire              wb0 = w_got_r ? wstrb0_r : s_axi_wstrb[0];
   wire pdwc_pkg::pdwc_sel_t wsel = dec(wa);
   wire wr_en    = wr_fire & wb0;
   wire wr_wake  = wr_en & (wsel == pdwc_pkg::SEL_WAKE);
   wire wr_misc  = wr_en & (wsel == pdwc_pkg::SEL_MISC);
   wire wr_ist   = wr_en & (wsel == pdwc_pkg::SEL_IST);
   wire wr_imsk  = wr_en & (wsel == pdwc_pkg::SEL_IMSK);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= 8'h00;
         wstrb0_r      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         aw_got_r      <= aw_got_nxt;
         w_got_r       <= w_got_nxt;
         s_axi_awready <= ~aw_got_nxt & ~bvalid_nxt;
         s_axi_wready  <= ~w_got_nxt & ~bvalid_nxt;
         s_axi_bvalid  <= bvalid_nxt;
         if (aw_fire)
            awaddr_r <= s_axi_awaddr;
         if (w_fire) begin
            wdata_r  <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
         end
         if (wr_fire)
            s_axi_bresp <= (wsel == pdwc_pkg::SEL_NONE) ? 2'h2 : 2'h0;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic                  wake_mux_en_r;
   logic                  keypad_irq_en_r;
   logic                  keypad_irq_flag_r;
   logic                  power_down_req_r;
   logic                  kp_prev_r;
   logic [2:0]            irq_stat_r;
   logic [2:0]            irq_mask_r;
   pdwc_pkg::pdwc_state_t state_r;
   pdwc_pkg::pdwc_state_t state_nxt;
   logic [9:0]            cnt_r;

   wire ar_fire   = s_axi_arvalid & s_axi_arready;
   wire pdwc_pkg::pdwc_sel_t rsel = dec(s_axi_araddr);
   wire rd_wake   = ar_fire & (rsel == pdwc_pkg::SEL_WAKE);
   wire kp_event  = kp_s & ~kp_prev_r;
   wire pd_start  = wr_misc & wd[`PDWC_MC_PDREQ_BIT] & ~power_down_req_r;
   wire wake_src  = (keypad_irq_flag_r & keypad_irq_en_r) | card_s | (|usr_s);
   wire merged    = wake_mux_en_r & wake_src;
   wire cnt_done  = (cnt_r == 10'h001);
   wire wake_done = (state_r == pdwc_pkg::ST_COUNT) & cnt_done;
   wire pd_enter  = (state_r == pdwc_pkg::ST_PD_DELAY) & cnt_done;
   wire [2:0] ev  = {pd_enter, wake_done, kp_event};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_mux_en_r     <= 1'b0;
         keypad_irq_en_r   <= 1'b0;
         keypad_irq_flag_r <= 1'b0;
         power_down_req_r  <= 1'b0;
         serial_loopback   <= 1'b0;
         serial_pin_sel    <= 1'b0;
         kp_prev_r         <= 1'b0;
         irq_stat_r        <= `PDWC_IRQ_RST;
         irq_mask_r        <= `PDWC_IRQ_RST;
      end else begin
         kp_prev_r <= kp_s;
         if (wr_wake) begin
            wake_mux_en_r   <= wd[`PDWC_WR_MUX_BIT];
            keypad_irq_en_r <= wd[`PDWC_WR_KPEN_BIT];
         end else if (rd_wake) begin
            wake_mux_en_r <= 1'b0;
         end
         // Event beats a software clear
         if (kp_event)
            keypad_irq_flag_r <= 1'b1;
         else if (wr_wake & ~wd[`PDWC_WR_KPFLAG_BIT])
            keypad_irq_flag_r <= 1'b0;
         if (wr_misc) begin
            serial_loopback <= wd[`PDWC_MC_LOOP_BIT];
            serial_pin_sel  <= wd[`PDWC_MC_PSEL_BIT];
         end
         if (wake_done)
            power_down_req_r <= 1'b0;
         else if (wr_misc)
            power_down_req_r <= wd[`PDWC_MC_PDREQ_BIT];
         irq_stat_r <= ev | (irq_stat_r & ~({3{wr_ist}} & wd[2:0]));
         if (wr_imsk)
            irq_mask_r <= wd[2:0];
      end
   end

   // ----------------------------------------------------------------
   // Power-down and wake sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         pdwc_pkg::ST_RUN: begin
            if (pd_start)
               state_nxt = pdwc_pkg::ST_PD_DELAY;
            else if (merged & ~ext_irq_zero)
               state_nxt = pdwc_pkg::ST_COUNT;
         end
         pdwc_pkg::ST_PD_DELAY: begin
            if (cnt_done)
               state_nxt = pdwc_pkg::ST_SLEEP;
         end
         pdwc_pkg::ST_SLEEP: begin
            if (merged)
               state_nxt = pdwc_pkg::ST_WAIT_CLK;
         end
         pdwc_pkg::ST_WAIT_CLK: begin
            if (clkok_s)
               state_nxt = pdwc_pkg::ST_COUNT;
         end
         pdwc_pkg::ST_COUNT: begin
            if (cnt_done)
               state_nxt = pdwc_pkg::ST_RUN;
         end
         default: state_nxt = pdwc_pkg::ST_RUN;
      endcase
   end

   wire enter_cnt = (state_nxt == pdwc_pkg::ST_COUNT) &
                    (state_r != pdwc_pkg::ST_COUNT);
   wire sleep_nxt = (state_nxt == pdwc_pkg::ST_SLEEP);
   wire held_nxt  = (state_nxt != pdwc_pkg::ST_RUN) &
                    (state_nxt != pdwc_pkg::ST_COUNT | power_down_req_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r        <= pdwc_pkg::ST_RUN;
         cnt_r          <= 10'h000;
         osc_pll_off    <= 1'b0;
         converter_off  <= 1'b0;
         core_standby   <= 1'b0;
         cpu_halt       <= 1'b0;
         ext_irq_zero   <= 1'b0;
         card_irq_out   <= 1'b0;
         keypad_irq_req <= 1'b0;
         irq            <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (pd_start & (state_r == pdwc_pkg::ST_RUN))
            cnt_r <= `PDWC_PD_DELAY_CYC;
         else if (enter_cnt)
            cnt_r <= `PDWC_WAKE_DELAY_CYC;
         else if (cnt_r != 10'h000)
            cnt_r <= cnt_r - 10'h001;
         osc_pll_off   <= sleep_nxt;
         converter_off <= sleep_nxt & ~bus_s & ~on_s;
         core_standby  <= sleep_nxt & (bus_s | on_s);
         cpu_halt      <= held_nxt;
         // Wake pulse holds until software reads the routing register
         if (wake_done)
            ext_irq_zero <= 1'b1;
         else if (rd_wake)
            ext_irq_zero <= 1'b0;
         else
            ext_irq_zero <= ext_irq_zero | (~wake_mux_en_r & (|usr_s));
         card_irq_out   <= card_s & ~wake_mux_en_r;
         keypad_irq_req <= keypad_irq_flag_r & keypad_irq_en_r
                           & ~wake_mux_en_r;
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   logic [7:0] rmux;

   always_comb begin
      rmux = 8'h00;
      unique case (rsel)
         pdwc_pkg::SEL_WAKE:
            rmux = {wake_mux_en_r, 5'h00, keypad_irq_en_r, keypad_irq_flag_r};
         pdwc_pkg::SEL_MISC:
            rmux = {power_down_req_r, 5'h00, serial_loopback, serial_pin_sel};
         pdwc_pkg::SEL_IST:  rmux = {5'h00, irq_stat_r};
         pdwc_pkg::SEL_IMSK: rmux = {5'h00, irq_mask_r};
         pdwc_pkg::SEL_STAT: rmux = {osc_pll_off, converter_off, core_standby,
                                     cpu_halt, 1'b0, state_r};
         pdwc_pkg::SEL_NONE: rmux = 8'h00;
         default:            rmux = 8'h00;
      endcase
   end

   wire rvalid_nxt = ar_fire | (s_axi_rvalid & ~s_axi_rready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= ~rvalid_nxt;
         s_axi_rvalid  <= rvalid_nxt;
         if (ar_fire) begin
            s_axi_rdata <= {24'h000000, rmux};
            s_axi_rresp <= (rsel == pdwc_pkg::SEL_NONE) ? 2'h2 : 2'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [10:0] wk_cycles_r;

   always_ff @(posedge aclk) begin
      if (!aresetn)
         wk_cycles_r <= 11'h000;
      else if (state_r == pdwc_pkg::ST_COUNT)
         wk_cycles_r <= wk_cycles_r + 11'h001;
      else
         wk_cycles_r <= 11'h000;
   end

   AST_MUX_MERGE: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == pdwc_pkg::ST_RUN && merged && !pd_start && !ext_irq_zero)
      |=> state_r == pdwc_pkg::ST_COUNT)
      else $error("merged wake source did not start the delay");

   AST_WAKE_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(ext_irq_zero) && $past(wake_done) |-> wk_cycles_r == 11'h200)
      else $error("wake interrupt not 512 cycles after clock start");

   AST_READ_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_wake && !wr_wake) |=> !wake_mux_en_r)
      else $error("wake-mux bit survived a register read");

   AST_PD_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
      (pd_start && state_r == pdwc_pkg::ST_RUN)
      |-> ##32 !osc_pll_off ##1 osc_pll_off)
      else $error("oscillator not off exactly 32 cycles after request");

   AST_HALT_SLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
      osc_pll_off |-> cpu_halt && power_down_req_r)
      else $error("cpu running or request clear while clocks off");

   AST_LOOPBACK: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_misc |=> serial_loopback == $past(wd[1]))
      else $error("loopback bit not taken from write");

   AST_PINSEL: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_misc |=> serial_pin_sel == $past(wd[0]))
      else $error("pin select bit not taken from write");

   AST_RST_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> !wake_mux_en_r && !keypad_irq_en_r
         && !power_down_req_r && !serial_loopback && !serial_pin_sel)
      else $error("control registers not zero after reset");

   AST_CONV_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == pdwc_pkg::ST_SLEEP && sleep_nxt)
      |=> converter_off == !($past(bus_s) || $past(on_s))
          && core_standby == ($past(bus_s) || $past(on_s)))
      else $error("converter or standby choice wrong in power-down");

   AST_WAIT_CLK: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == pdwc_pkg::ST_WAIT_CLK && !clkok_s)
      |=> state_r == pdwc_pkg::ST_WAIT_CLK && !osc_pll_off)
      else $error("wake count began before clock was running");

   AST_KEYPAD: assert property (@(posedge aclk) disable iff (!aresetn)
      keypad_irq_req |-> $past(keypad_irq_flag_r && keypad_irq_en_r))
      else $error("keypad interrupt without enabled flag");

endmodule : pdwc_top

// >>> include/pdwc_regs.svh
`ifndef PDWC_REGS_SVH
`define PDWC_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define PDWC_WAKE_ROUTE_IDX   16'hff94
`define PDWC_MISC_CTRL_IDX    16'hfff1
`define PDWC_IRQ_STAT_IDX     16'h0100
`define PDWC_IRQ_MASK_IDX     16'h0101
`define PDWC_BLK_STAT_IDX     16'h0102

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PDWC_WR_MUX_BIT       7
`define PDWC_WR_KPEN_BIT      1
`define PDWC_WR_KPFLAG_BIT    0
`define PDWC_MC_PDREQ_BIT     7
`define PDWC_MC_LOOP_BIT      1
`define PDWC_MC_PSEL_BIT      0
`define PDWC_IRQ_KEYPAD_BIT   0
`define PDWC_IRQ_WAKE_BIT     1
`define PDWC_IRQ_PDOWN_BIT    2

// ----------------------------------------------------------------
// Reset values and timing counts (MPU clock cycles)
// ----------------------------------------------------------------
`define PDWC_CTRL_RST         8'h00
`define PDWC_IRQ_RST          3'h0
`define PDWC_PD_DELAY_CYC     10'h020
`define PDWC_WAKE_DELAY_CYC   10'h200

`endif

// >>> include/pdwc_pkg.sv
package pdwc_pkg;

   typedef enum logic [2:0] {
      ST_RUN      = 3'b000,
      ST_PD_DELAY = 3'b001,
      ST_SLEEP    = 3'b010,
      ST_WAIT_CLK = 3'b011,
      ST_COUNT    = 3'b100
   } pdwc_state_t;

   typedef enum logic [2:0] {
      SEL_NONE  = 3'b000,
      SEL_WAKE  = 3'b001,
      SEL_MISC  = 3'b010,
      SEL_IST   = 3'b011,
      SEL_IMSK  = 3'b100,
      SEL_STAT  = 3'b101
   } pdwc_sel_t;

endpackage : pdwc_pkg

// >>> verilog/pdwc_sync.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Two-flop synchroniser for pin inputs
// ----------------------------------------------------------------
module pdwc_sync #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : pdwc_sync

// >>> tb/pdwc_cpu_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Core as seen from its stop and interrupt inputs
// ----------------------------------------------------------------
module pdwc_cpu_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       cpu_halt,
   input  wire logic       osc_pll_off,
   input  wire logic       ext_irq_zero,
   output logic            stop_ok,
   output logic [7:0]      wake_cnt
);
   logic stopped_r;
   logic osc_d_r;
   logic irq_d_r;
   wire  osc_rise = osc_pll_off & ~osc_d_r;
   wire  irq_rise = ext_irq_zero & ~irq_d_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stopped_r <= 1'b0;
         osc_d_r   <= 1'b0;
         irq_d_r   <= 1'b0;
         stop_ok   <= 1'b1;
         wake_cnt  <= 8'h00;
      end else begin
         osc_d_r   <= osc_pll_off;
         irq_d_r   <= ext_irq_zero;
         // Stop executes as the next instruction after the halt request
         stopped_r <= cpu_halt;
         // Clocks vanishing under a running core is a failure
         if (osc_rise && !stopped_r) begin
            stop_ok <= 1'b0;
         end
         if (irq_rise) begin
            wake_cnt <= wake_cnt + 8'h01;
         end
      end
   end
endmodule : pdwc_cpu_model

// >>> tb/tb.sv
`timescale 1ns/1ns
`include "pdwc_regs.svh"
module tb;
   localparam int LIMIT = 20000;
   localparam logic [17:0] A_WAKE = {`PDWC_WAKE_ROUTE_IDX, 2'b00};
   localparam logic [17:0] A_MISC = {`PDWC_MISC_CTRL_IDX, 2'b00};
   localparam logic [17:0] A_IST  = {`PDWC_IRQ_STAT_IDX, 2'b00};
   localparam logic [17:0] A_IMSK = {`PDWC_IRQ_MASK_IDX, 2'b00};
   localparam logic [17:0] A_BAD  = 18'h00010;
   typedef struct packed {
      logic [17:0] a;
      logic [7:0]  d;
      logic [7:0]  q;
      logic [1:0]  resp;
      logic [1:0]  pins;
   } pdwc_row_t;
   pdwc_row_t rows [5] = '{'{A_MISC, 8'h03, 8'h03, 2'b00, 2'b11},
      '{A_MISC, 8'h02, 8'h02, 2'b00, 2'b10},
      '{A_MISC, 8'h01, 8'h01, 2'b00, 2'b01},
      '{A_MISC, 8'h00, 8'h00, 2'b00, 2'b00},
      '{A_BAD, 8'h03, 8'h00, 2'b10, 2'b00}};
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        keypad_evt, card_irq, bus_supply_ok, onoff_is_on, clk_stable;
   logic [7:0]  user_pins, wake_cnt;
   logic        ext_irq_zero, keypad_irq_req, osc_pll_off, converter_off;
   logic        core_standby, cpu_halt, serial_loopback, serial_pin_sel;
   logic        irq, stop_ok;
   int          cyc = 0;
   int          hs_cyc = 0;
   int          mismatches = 0;
   int          total_checks = 0;

   pdwc_top pdwc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .keypad_evt, .card_irq,
      .user_pins, .bus_supply_ok, .onoff_is_on, .clk_stable, .ext_irq_zero,
      .card_irq_out(), .keypad_irq_req, .osc_pll_off, .converter_off,
      .core_standby, .cpu_halt, .serial_loopback, .serial_pin_sel, .irq);
   pdwc_cpu_model pdwc_cpu_model_inst (.aclk, .aresetn, .cpu_halt,
      .osc_pll_off, .ext_irq_zero, .stop_ok, .wake_cnt);

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic test_done;
      $display("Checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         mismatches++;
         $display("Error at %0t: timeout", $time);
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [17:0] a, input logic [7:0] d,
                     output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      @(posedge aclk);
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      hs_cyc = cyc;
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [17:0] a, output logic [31:0] q,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      q = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!ext_irq_zero && n < 1000);
   endtask : wait_irq

   initial begin
      logic [31:0] q;
      logic [1:0]  r;
      int          n;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, keypad_evt, card_irq} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, user_pins} = '0;
      s_axi_wstrb = 4'hf;
      {bus_supply_ok, onoff_is_on, clk_stable} = 3'h7;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_WAKE, q, r);
      chk(q, 32'h0, "wake route reset");
      rd(A_MISC, q, r);
      chk(q, 32'h0, "misc reset");
      chk(32'({osc_pll_off, cpu_halt, ext_irq_zero, irq}), 0, "outs");
      $display("Test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, r);
         chk(32'(r), 32'(rows[i].resp), "bresp");
         rd(rows[i].a, q, r);
         chk(q, {24'h0, rows[i].q}, "rdata");
         chk(32'(r), 32'(rows[i].resp), "rresp");
         chk(32'({serial_loopback, serial_pin_sel}), 32'(rows[i].pins),
             "serial pins");
      end
      $display("Test register table done");
      keypad_evt <= 1'b1;
      repeat (3) @(posedge aclk);
      keypad_evt <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(32'(keypad_irq_req), 0, "keypad masked");
      rd(A_WAKE, q, r);
      chk(q, 32'h01, "keypad flag");
      wr(A_WAKE, 8'h03, r);
      repeat (4) @(posedge aclk);
      chk(32'(keypad_irq_req), 1, "keypad enabled");
      wr(A_WAKE, 8'h02, r);
      repeat (4) @(posedge aclk);
      chk(32'(keypad_irq_req), 0, "keypad flag cleared");
      rd(A_IST, q, r);
      chk(q & 32'h1, 32'h1, "keypad status");
      $display("Test keypad done");
      wr(A_IST, 8'h07, r);
      wr(A_WAKE, 8'h80, r);
      wr(A_MISC, 8'h80, r);
      n = hs_cyc;
      while (!osc_pll_off) @(posedge aclk);
      chk(32'(cyc - n), 33, "power-down delay");
      chk(32'({cpu_halt, stop_ok}), 3, "core halted");
      repeat (4) @(posedge aclk);
      chk(32'({converter_off, core_standby}), 1, "standby");
      {bus_supply_ok, onoff_is_on, clk_stable} <= 3'h0;
      repeat (5) @(posedge aclk);
      chk(32'({converter_off, core_standby}), 2, "converter off");
      card_irq <= 1'b1;
      repeat (5) @(posedge aclk);
      chk(32'(osc_pll_off), 0, "clocks restart");
      repeat (600) @(posedge aclk);
      chk(32'(ext_irq_zero), 0, "count waits for clock");
      {bus_supply_ok, onoff_is_on, clk_stable} <= 3'h7;
      wait_irq(n);
      chk(32'(n >= 512 && n <= 520), 1, "wake delay");
      card_irq <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(32'({cpu_halt, wake_cnt}), 1, "core resumed");
      rd(A_MISC, q, r);
      chk(q, 32'h0, "request cleared");
      rd(A_IST, q, r);
      chk(q, 32'h06, "event status");
      rd(A_WAKE, q, r);
      chk(q, 32'h80, "mux read");
      rd(A_WAKE, q, r);
      chk(q, 32'h00, "mux cleared by read");
      wr(A_IMSK, 8'h04, r);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 1, "irq unmasked");
      wr(A_IST, 8'h04, r);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 0, "irq cleared, bit1 masked");
      $display("Test power-down done");
      for (int s = 0; s < 3; s++) begin
         wr(A_WAKE, (s == 0) ? 8'h82 : 8'h80, r);
         keypad_evt <= (s == 0);
         card_irq <= (s == 1);
         user_pins <= (s == 2) ? 8'h80 : 8'h00;
         wait_irq(n);
         chk(32'(n >= 512 && n <= 520), 1, "merged wake");
         {keypad_evt, card_irq, user_pins} <= '0;
         rd(A_WAKE, q, r);
         wr(A_WAKE, 8'h00, r);
         repeat (3) @(posedge aclk);
         chk(32'(ext_irq_zero), 0, "wake dropped");
      end
      $display("Test wake sources done");
      test_done();
   end
endmodule : tb
